/* File: inc/lpc_pkg.sv */
// shared constants, types and register map of the low-power clock control
package lpc_pkg;

    // register byte offsets
    localparam logic [11:0] MODE_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;

    // mode register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    // control register fields
    localparam int ADIV_LSB = 0;
    localparam int AOUT_EN_BIT = 2;
    localparam int MOUT_EN_BIT = 3;

    // reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [1:0] ADIV_RST = 2'h0;

    // divider width for the auxiliary pin clock (up to divide by 8)
    localparam int ADIV_CNT_W = 3;

    // operating modes, as written in the mode field
    typedef enum logic [2:0] {
        full_run_mode = 3'h0,
        sleep_level_zero = 3'h1,
        sleep_level_one = 3'h2,
        sleep_level_two = 3'h3,
        sleep_level_three = 3'h4,
        sleep_level_four = 3'h5
    } lpc_mode_e;

    // clock and power enables derived from a mode
    typedef struct packed {
        logic cpu_run;
        logic aux_clk;
        logic sub_main_clk;
        logic main_clk;
        logic fll_reg;
        logic osc_clk;
        logic osc_dc_gen;
        logic xtal_run;
    } lpc_en_s;

    // wake controller states, Gray order along the sleep/wake path
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b11
    } lpc_state_e;

endpackage

/* File: hdl/lpc_aux_div.sv */
// auxiliary clock divider producing a pin level of aux / 1, 2, 4 or 8
module lpc_aux_div (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic aux_tick,
    input wire logic [1:0] div_sel,
    input wire logic enable,
    // divided level
    output logic div_out
);

    logic [lpc_pkg::ADIV_CNT_W-1:0] cnt_r;

    // free counter advanced on each aux tick; a bit of it is the output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!enable) begin
            cnt_r <= '0;
        end else if (aux_tick) begin
            cnt_r <= cnt_r + lpc_pkg::ADIV_CNT_W'(1);
        end
    end

    // divide by 1 follows the tick itself; others take counter bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_out <= 1'b0;
        end else if (!enable) begin
            div_out <= 1'b0;
        end else begin
            unique case (div_sel)
                2'h0: div_out <= aux_tick;
                2'h1: div_out <= cnt_r[0];
                2'h2: div_out <= cnt_r[1];
                2'h3: div_out <= cnt_r[2];
            endcase
        end
    end

endmodule

/* File: hdl/lpc_top.sv */
// low-power mode selection and clock gating with APB registers

// ==========================================================
// What this block does
// R01: one run mode and five sleep modes
// R02: interrupt wakes, return restores prior sleep
// R03: run mode enables every clock and processor
// R04: level zero: cpu off, clocks and regulation on
// R05: level one: like zero, regulation off
// R06: level two: main, regulation, oscillator off
// R07: level three: also DC generator off
// R08: level four: everything off, crystal stopped
// R09: aux clock to pin divided; main to pin
// R10: mode comes from software-written mode field
module lpc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor handshake
    input wire logic irq_pending,
    input wire logic irq_return,
    // auxiliary clock rate from the slow oscillator
    input wire logic aux_tick_pin,
    // gate enables
    output lpc_pkg::lpc_en_s clk_en,
    // pin clocks
    output logic aux_pin_clk,
    output logic main_pin_clk
);

    // ==========================================================
    // state
    lpc_pkg::lpc_mode_e mode_r;
    lpc_pkg::lpc_mode_e saved_r;
    lpc_pkg::lpc_state_e st_r;
    logic [1:0] adiv_r;
    logic aout_en_r;
    logic mout_en_r;
    logic tick_s1_r;
    logic tick_s2_r;
    logic tick_d_r;
    logic aux_tick;
    logic wr_en;
    logic [31:0] rd_nxt;
    lpc_pkg::lpc_en_s en_nxt;

    // decode a mode into its enables
    function automatic lpc_pkg::lpc_en_s mode_enables(
        input lpc_pkg::lpc_mode_e m);
        lpc_pkg::lpc_en_s e;
        e = '0;
        unique case (m)
            // R03 all running
            lpc_pkg::full_run_mode: e = '1;
            // R04 cpu halted only
            lpc_pkg::sleep_level_zero: begin
                e = '1;
                e.cpu_run = 1'b0;
            end
            // R05 regulation also off
            lpc_pkg::sleep_level_one: begin
                e = '1;
                e.cpu_run = 1'b0;
                e.fll_reg = 1'b0;
            end
            // R06 aux, dc generator and crystal kept
            lpc_pkg::sleep_level_two: begin
                e.aux_clk = 1'b1;
                e.osc_dc_gen = 1'b1;
                e.xtal_run = 1'b1;
            end
            // R07 only aux and crystal kept
            lpc_pkg::sleep_level_three: begin
                e.aux_clk = 1'b1;
                e.xtal_run = 1'b1;
            end
            // R08 everything off
            lpc_pkg::sleep_level_four: e = '0;
            default: e = '1;
        endcase
        return e;
    endfunction

    // ==========================================================
    // apb slave, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;

    // unmapped or illegal mode writes report an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            unique case (paddr)
                lpc_pkg::MODE_OFS:
                    pslverr = pwrite && (pwdata[2:0] > 3'h5);
                lpc_pkg::CTRL_OFS: pslverr = 1'b0;
                lpc_pkg::STAT_OFS: pslverr = pwrite;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_nxt = '0;
        unique case (paddr)
            lpc_pkg::MODE_OFS: rd_nxt[2:0] = mode_r;
            lpc_pkg::CTRL_OFS: begin
                rd_nxt[1:0] = adiv_r;
                rd_nxt[lpc_pkg::AOUT_EN_BIT] = aout_en_r;
                rd_nxt[lpc_pkg::MOUT_EN_BIT] = mout_en_r;
            end
            lpc_pkg::STAT_OFS: begin
                rd_nxt[1:0] = st_r;
                rd_nxt[6:4] = saved_r;
                rd_nxt[15:8] = clk_en;
            end
            default: rd_nxt = '0;
        endcase
    end

    // read data registered in the setup cycle, valid at access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adiv_r <= lpc_pkg::ADIV_RST;
            aout_en_r <= 1'b0;
            mout_en_r <= 1'b0;
        end else if (wr_en && paddr == lpc_pkg::CTRL_OFS) begin
            adiv_r <= pwdata[lpc_pkg::ADIV_LSB +: 2];
            aout_en_r <= pwdata[lpc_pkg::AOUT_EN_BIT];
            mout_en_r <= pwdata[lpc_pkg::MOUT_EN_BIT];
        end
    end

    // ==========================================================
    // mode and wake sequencing
    // R10 mode field write; R02 wake and restore
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= lpc_pkg::full_run_mode;
            saved_r <= lpc_pkg::full_run_mode;
            st_r <= lpc_pkg::ST_RUN;
        end else begin
            unique case (st_r)
                lpc_pkg::ST_RUN: begin
                    if (wr_en && paddr == lpc_pkg::MODE_OFS &&
                        pwdata[2:0] <= 3'h5) begin
                        mode_r <= lpc_pkg::lpc_mode_e'(pwdata[2:0]);
                        if (pwdata[2:0] != 3'h0) begin
                            st_r <= lpc_pkg::ST_SLEEP;
                        end
                    end
                end
                lpc_pkg::ST_SLEEP: begin
                    // a pending interrupt forces full run for service
                    if (irq_pending) begin
                        saved_r <= mode_r;
                        mode_r <= lpc_pkg::full_run_mode;
                        st_r <= lpc_pkg::ST_WAKE;
                    end
                end
                lpc_pkg::ST_WAKE: begin
                    // handler may clear the sleep by writing run mode
                    if (wr_en && paddr == lpc_pkg::MODE_OFS &&
                        pwdata[2:0] == 3'h0) begin
                        saved_r <= lpc_pkg::full_run_mode;
                        st_r <= lpc_pkg::ST_RUN;
                    end else if (irq_return) begin
                        mode_r <= saved_r;
                        st_r <= lpc_pkg::ST_SLEEP;
                    end
                end
                default: st_r <= lpc_pkg::ST_RUN;
            endcase
        end
    end

    // R01 gate enables registered from the mode
    assign en_nxt = mode_enables(mode_r);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en <= '1;
        end else begin
            clk_en <= en_nxt;
        end
    end

    // ==========================================================
    // pin clocks
    // pin tick synchronised; edge taken after the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_d_r <= 1'b0;
        end else begin
            tick_s1_r <= aux_tick_pin;
            tick_s2_r <= tick_s1_r;
            tick_d_r <= tick_s2_r;
        end
    end
    assign aux_tick = tick_s2_r && !tick_d_r;

    // R09 divided aux to pin, stops with the aux clock
    lpc_aux_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .aux_tick(aux_tick),
        .div_sel(adiv_r),
        .enable(aout_en_r && clk_en.aux_clk),
        .div_out(aux_pin_clk)
    );

    // R09 main clock to pin as a gate level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_pin_clk <= 1'b0;
        end else begin
            main_pin_clk <= mout_en_r && clk_en.main_clk;
        end
    end

endmodule

/* File: testbench/lpc_checker.sv */
// port assertions for the low-power clock control
module lpc_checker (
    // clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // handshake and clocks
    input wire logic irq_pending,
    input wire lpc_pkg::lpc_en_s clk_en,
    input wire logic main_pin_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =========================================
    // write strobes seen at the access edge
    wire logic wr_mode = psel && penable && pwrite
        && paddr == lpc_pkg::MODE_OFS;
    wire logic wr_ctrl = psel && penable && pwrite
        && paddr == lpc_pkg::CTRL_OFS;
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_run;
        clk_en.cpu_run |-> clk_en == 8'hFF;
    endproperty
    a_run: assert property (p_run) else $error("run gating");
    property p_fll;
        clk_en.fll_reg |-> clk_en.main_clk && clk_en.sub_main_clk
            && clk_en.aux_clk;
    endproperty
    a_fll: assert property (p_fll) else $error("regulation");
    property p_main;
        !clk_en.main_clk |-> !(clk_en.fll_reg || clk_en.osc_clk);
    endproperty
    a_main: assert property (p_main) else $error("main off");
    property p_dcgen;
        !clk_en.osc_dc_gen |-> !clk_en.osc_clk && !clk_en.main_clk;
    endproperty
    a_dcgen: assert property (p_dcgen) else $error("dc gen");
    property p_xtal;
        !clk_en.xtal_run |-> !(clk_en.aux_clk || clk_en.osc_dc_gen);
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal");
    property p_wake;
        irq_pending && !clk_en.cpu_run |-> ##[1:3] clk_en.cpu_run;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_bad;
        wr_mode && pwdata[2:0] > 3'h5 |-> pslverr;
    endproperty
    a_bad: assert property (p_bad) else $error("bad mode");
    property p_sleep;
        wr_mode && pwdata[2:0] inside {[1:5]} && clk_en.cpu_run
            |-> ##[1:2] !clk_en.cpu_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_mpin;
        wr_ctrl && !pwdata[3] |-> ##[1:2] !main_pin_clk;
    endproperty
    a_mpin: assert property (p_mpin) else $error("main pin");
    c_wake: cover property (irq_pending && !clk_en.cpu_run);
    c_off: cover property (!clk_en.xtal_run);
    c_err: cover property (psel && penable && pslverr);
endmodule

bind lpc_top lpc_checker i_lpc_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .irq_pending(irq_pending), .clk_en(clk_en),
    .main_pin_clk(main_pin_clk));

/* File: testbench/lpc_core_model.sv */
// processor model: takes an interrupt, then leaves its handler
module lpc_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench request and gated clocks
    input wire logic wake_req,
    input wire lpc_pkg::lpc_en_s clk_en,
    // handshake to the block
    output logic irq_pending,
    output logic irq_return
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] svc_r;
    // hold request until running, return later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending <= 1'b0;
            irq_return <= 1'b0;
            svc_r <= 3'h0;
        end else begin
            irq_return <= svc_r == 3'h1;
            if (svc_r != 3'h0)
                svc_r <= svc_r - 3'h1;
            if (wake_req)
                irq_pending <= 1'b1;
            else if (irq_pending && clk_en.cpu_run) begin
                irq_pending <= 1'b0;
                svc_r <= 3'h4;
            end
        end
    end
endmodule

/* File: testbench/lpc_top_tb.sv */
// bench: bus access, sleep levels, wake and pin clocks
module lpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic irq_pending, irq_return, aux_tick_pin, wake_req, prev;
    logic aux_pin_clk, main_pin_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    lpc_pkg::lpc_en_s clk_en;
    int n_mismatch = 0, compares = 0, cyc = 0, rises = 0;
    // expected gating per mode, only bits that the modes define
    logic [7:0] l_exp [6] = '{8'hFF, 8'h78, 8'h70, 8'h43, 8'h41, 8'h00};
    logic [7:0] l_msk [6] = '{8'hFF, 8'hF8, 8'hF8, 8'hDF, 8'hDF, 8'hDF};
    lpc_top i_lpc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending),
        .irq_return(irq_return), .aux_tick_pin(aux_tick_pin),
        .clk_en(clk_en), .aux_pin_clk(aux_pin_clk),
        .main_pin_clk(main_pin_clk));
    lpc_core_model i_lpc_core_model (.pclk(pclk), .presetn(presetn),
        .wake_req(wake_req), .clk_en(clk_en),
        .irq_pending(irq_pending), .irq_return(irq_return));
    // =========================================
    // clock, hang limit and pin edge counter
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        prev <= aux_pin_clk;
        if (aux_pin_clk === 1'b1 && prev === 1'b0)
            rises <= rises + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, exp, msk);
        compares++;
        if ((got & msk) !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; only the hang limit ends the wait for pready
    // an idle edge after release keeps psel from toggling in one step
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wake();
        wake_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // =========================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, aux_tick_pin, wake_req} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(clk_en, 8'hFF, 8'hFF);
        // refused writes leave the mode alone
        apb(1'b1, lpc_pkg::MODE_OFS, 32'h6);
        chk(err, 1, 1);
        apb(1'b1, 12'h00C, 32'h1);
        chk(err, 1, 1);
        apb(1'b1, lpc_pkg::STAT_OFS, 32'h1);
        chk(err, 1, 1);
        apb(1'b0, lpc_pkg::MODE_OFS, 32'h0);
        chk(rd, 0, 7);
        // every sleep level, woken and restored
        for (int m = 1; m < 6; m++) begin
            apb(1'b1, lpc_pkg::MODE_OFS, 32'(m));
            chk(err, 32'h0, 32'h1);
            repeat (3) @(posedge pclk);
            chk(clk_en, l_exp[m], l_msk[m]);
            wake();
            chk(clk_en, 8'hFF, 8'hFF);
            apb(1'b0, lpc_pkg::STAT_OFS, 32'h0);
            chk(rd, 32'(m * 16 + 3), 32'h73);
            repeat (8) @(posedge pclk);
            chk(clk_en, l_exp[m], l_msk[m]);
            wake();
            apb(1'b1, lpc_pkg::MODE_OFS, 32'h0);
            repeat (8) @(posedge pclk);
            chk(clk_en, 8'hFF, 8'hFF);
        end
        // aux pin divided by 1, 2, 4, 8; main pin gated
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, lpc_pkg::CTRL_OFS, 32'hC | 32'(d));
            rises = 0;
            repeat (16) begin
                aux_tick_pin <= 1'b1;
                repeat (4) @(posedge pclk);
                aux_tick_pin <= 1'b0;
                repeat (4) @(posedge pclk);
            end
            chk(rises, 16 >> d, 32'hFFFFFFFF);
        end
        chk(main_pin_clk, 1, 1);
        apb(1'b0, lpc_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'hF, 32'hF);
        chk(err, 32'h0, 32'h1);
        apb(1'b1, lpc_pkg::CTRL_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk(main_pin_clk, 0, 1);
        end_sim();
    end
endmodule
